/* File: hdl/bmsf_regs.svh */
// constants of the bus-matching synchronous fifo
// assumes inclusion by the top module only
`ifndef BMSF_REGS_SVH
`define BMSF_REGS_SVH

`define BMSF_DATA_W 36
`define BMSF_HALF_W 18
`define BMSF_BYTE_W 9
`define BMSF_DEPTH 4096
`define BMSF_DEFAULT_OFFSET 8
// cycles from reset assertion until the empty/output-ready output drops
`define BMSF_EF_RST_DLY_STD 2'h2
`define BMSF_EF_RST_DLY_FALL_THROUGH_SELECT 2'h1
// last part index per read width
`define BMSF_LAST_IDX_LONG 2'h0
`define BMSF_LAST_IDX_HALF 2'h1
`define BMSF_LAST_IDX_BYTE 2'h3

`endif

/* File: hdl/bmsf_pkg.sv */
// types shared by the bus-matching synchronous fifo
// assumes the constants header is on the include path
package bmsf_pkg;

  // offset programming method chosen at master reset
  typedef enum logic [1:0] {
    BMSF_PROG_DEFAULT,
    BMSF_PROG_PARALLEL,
    BMSF_PROG_SERIAL
  } bmsf_prog_e;

  // configuring: offsets not yet loaded, writes refused
  typedef enum logic {
    BMSF_CFG,
    BMSF_RUN
  } bmsf_phase_e;

endpackage

/* File: hdl/bmsf_top.sv */
// bus-matching synchronous fifo: 36-bit writer on port a, 36/18/9-bit reader on port b,
// programmable almost flags, retransmit and two mailboxes
// assumes one clock for both ports and inputs synchronous to it
//
// Functional notes
// - fall-through mode drops empty/output-ready one cycle sooner after reset.
// - fifo writes ignored while offsets programmed, until full/input-ready rises.
// - serial offset bits taken only on cycles with serial load enabled.
// - parallel offsets load from port a data on write cycles, mail deselected.
// - long-word mode presents stored word unchanged on port b.
// - half mode: two reads, big endian upper half first, little lower first.
// - half mode upper port b lines are undefined (driven zero here).
// - byte mode: four reads, big endian from top byte, little from bottom.
// - byte mode lines above lowest lane are undefined (driven zero here).
// - endian captured at reset; width selects held static by the outside.
// - fall-through: write into empty fifo raises output-ready and loads word.
// - narrow modes: empty/output-ready drop only after the last part read.
// - standard: write into empty fifo raises the empty flag after sync.
// - fall-through: read from full fifo raises input-ready after sync.
// - standard: read from full fifo raises full flag after sync.
// - narrow modes free space only when the last part is read.
// - almost-empty rises after sync, drops only on last-part read.
// - almost-full rises after sync, referenced to the last-part read.
// - retransmit done when empty/output-ready returns high; reader waits.
// - retransmit restarts reading at the first word written after reset.
// - a-to-b mailbox width follows port b width.
// - b-to-a mailbox width follows port b width.
// - mailbox write drops its flag, blocks writes; opposite read raises it.
// - endian sampled at master reset release, ignored in long-word mode.
`timescale 1ns/100ps
`include "bmsf_regs.svh"

module bmsf_top #(
  parameter int DEPTH = `BMSF_DEPTH,
  parameter int DEFAULT_OFFSET = `BMSF_DEFAULT_OFFSET
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic master_reset_n,
  input wire logic partial_reset_n,
  input wire logic retransmit_n,
  input wire logic endian_select,
  input wire logic fall_through_select,
  input wire logic bus_match_select,
  input wire logic byte_size_select,
  input wire bmsf_pkg::bmsf_prog_e program_mode,
  input wire logic serial_load_enable,
  input wire logic serial_offset_data,
  input wire logic port_a_chip_select_n,
  input wire logic port_a_direction,
  input wire logic port_a_enable,
  input wire logic port_a_mail_select,
  input wire logic [`BMSF_DATA_W-1:0] port_a_data_in,
  output logic [`BMSF_DATA_W-1:0] port_a_data_out,
  output logic port_a_data_oe,
  input wire logic port_b_chip_select_n,
  input wire logic port_b_direction,
  input wire logic port_b_enable,
  input wire logic port_b_mail_select,
  input wire logic [`BMSF_DATA_W-1:0] port_b_data_in,
  output logic [`BMSF_DATA_W-1:0] port_b_data_out,
  output logic port_b_data_oe,
  output logic full_or_input_ready,
  output logic empty_or_output_ready,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n,
  output logic a_to_b_mail_full_n,
  output logic b_to_a_mail_full_n
);
  import bmsf_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam int DW = `BMSF_DATA_W;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
  localparam logic [AW-1:0] DEF_OFS = AW'(DEFAULT_OFFSET);

  typedef struct packed {
    bmsf_phase_e phase;
    logic endianBig;
    logic mrPrev;
    logic [1:0] rstCnt;
    logic [PW-1:0] wptr;
    logic [PW-1:0] wptrS1;
    logic [PW-1:0] wptrS2;
    logic [PW-1:0] freePtr;
    logic [PW-1:0] freeS1;
    logic [PW-1:0] freeS2;
    logic [PW-1:0] rdPtr;
    logic [DW-1:0] buf0;
    logic [DW-1:0] buf1;
    logic [1:0] bufCnt;
    logic [DW-1:0] word;
    logic [1:0] partsLeft;
    logic [DW-1:0] dataOut;
    logic outValid;
    logic outLast;
    logic [AW-1:0] afOffset;
    logic [AW-1:0] aeOffset;
    logic [2*AW-1:0] shiftReg;
    logic [$clog2(2*AW+1)-1:0] shiftCnt;
    logic parCnt;
    logic [DW-1:0] mailAb;
    logic [DW-1:0] mailBa;
    logic mabFullN;
    logic mbaFullN;
  } bmsf_state_s;

  bmsf_state_s st_reg;
  bmsf_state_s st_next;
  logic [DW-1:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one part of a long word placed in the low lanes
  function automatic logic [DW-1:0] part_sel(input logic [DW-1:0] w, input logic [1:0] idx,
                                              input logic bm, input logic sz, input logic big);
    logic [1:0] lane;
    logic half;
    lane = big ? 2'h3 - idx : idx;
    half = big ? ~idx[0] : idx[0];
    if (!bm) begin
      return w;
    end else if (sz) begin
      return {27'h000_0000, w[lane*`BMSF_BYTE_W +: `BMSF_BYTE_W]};
    end else begin
      return {18'h0_0000, w[half*`BMSF_HALF_W +: `BMSF_HALF_W]};
    end
  endfunction

  // mailbox lanes limited to the port b width
  function automatic logic [DW-1:0] mail_mask(input logic [DW-1:0] w, input logic bm,
                                               input logic sz);
    if (!bm) begin
      return w;
    end else if (sz) begin
      return {27'h000_0000, w[`BMSF_BYTE_W-1:0]};
    end else begin
      return {18'h0_0000, w[`BMSF_HALF_W-1:0]};
    end
  endfunction

  // ----------------------------------------------------------------
  // decodes
  // ----------------------------------------------------------------
  logic selA;
  logic selB;
  logic fifoWrA;
  logic mailWrA;
  logic mailRdA;
  logic fifoRdB;
  logic mailWrB;
  logic mailRdB;
  logic inReset;
  logic fullN;
  logic avail;
  logic [1:0] lastIdx;
  logic [PW-1:0] wordsA;
  logic [PW-1:0] wordsB;

  assign selA = !port_a_chip_select_n && port_a_enable;
  assign selB = !port_b_chip_select_n && port_b_enable;
  assign fifoWrA = selA && port_a_direction && !port_a_mail_select;
  assign mailWrA = selA && port_a_direction && port_a_mail_select;
  assign mailRdA = selA && !port_a_direction && port_a_mail_select;
  assign fifoRdB = selB && port_b_direction && !port_b_mail_select;
  assign mailWrB = selB && !port_b_direction && port_b_mail_select;
  assign mailRdB = selB && port_b_direction && port_b_mail_select;
  assign inReset = !master_reset_n || !partial_reset_n;
  assign wordsA = st_reg.wptr - st_reg.freeS2;
  assign wordsB = st_reg.wptrS2 - st_reg.freePtr;
  assign fullN = (st_reg.phase == BMSF_RUN) && (wordsA != DEPTH_P);
  assign avail = (st_reg.partsLeft != 2'h0) || (st_reg.bufCnt != 2'h0);
  assign lastIdx = !bus_match_select ? `BMSF_LAST_IDX_LONG :
                   byte_size_select ? `BMSF_LAST_IDX_BYTE : `BMSF_LAST_IDX_HALF;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic advance;
    logic pop;
    logic push;
    logic [1:0] idx;
    logic [DW-1:0] src;
    logic [1:0] cnt;
    advance = 1'b0;
    pop = 1'b0;
    push = 1'b0;
    idx = 2'h0;
    src = st_reg.word;
    cnt = st_reg.bufCnt;
    st_next = st_reg;
    st_next.mrPrev = master_reset_n;
    if (master_reset_n && !st_reg.mrPrev) begin
      st_next.endianBig = endian_select;
    end
    st_next.wptrS1 = st_reg.wptr;
    st_next.wptrS2 = st_reg.wptrS1;
    st_next.freeS1 = st_reg.freePtr;
    st_next.freeS2 = st_reg.freeS1;

    // offset programming after master reset
    if (st_reg.phase == BMSF_CFG) begin
      if (program_mode == BMSF_PROG_SERIAL) begin
        if (serial_load_enable) begin
          st_next.shiftReg = {st_reg.shiftReg[2*AW-2:0], serial_offset_data};
          st_next.shiftCnt = st_reg.shiftCnt + 1'b1;
        end
        if (st_reg.shiftCnt == ($bits(st_reg.shiftCnt))'(2*AW)) begin
          st_next.afOffset = st_reg.shiftReg[2*AW-1:AW];
          st_next.aeOffset = st_reg.shiftReg[AW-1:0];
          st_next.phase = BMSF_RUN;
        end
      end else if (program_mode == BMSF_PROG_PARALLEL) begin
        if (fifoWrA) begin
          st_next.parCnt = 1'b1;
          if (!st_reg.parCnt) begin
            st_next.afOffset = port_a_data_in[AW-1:0];
          end else begin
            st_next.aeOffset = port_a_data_in[AW-1:0];
            st_next.phase = BMSF_RUN;
          end
        end
      end else begin
        st_next.phase = BMSF_RUN;
      end
    end

    // write side
    if (fifoWrA && fullN && !inReset) begin
      st_next.wptr = st_reg.wptr + 1'b1;
    end

    // read side output stage
    if (st_reg.outValid && st_reg.outLast && fifoRdB && fall_through_select) begin
      st_next.freePtr = st_reg.freePtr + 1'b1;
    end
    if (fall_through_select) begin
      advance = (!st_reg.outValid || fifoRdB) && avail;
      if ((!st_reg.outValid || fifoRdB) && !avail) begin
        st_next.outValid = 1'b0;
      end
    end else begin
      advance = fifoRdB && avail;
    end
    if (advance) begin
      if (st_reg.partsLeft != 2'h0) begin
        idx = lastIdx - st_reg.partsLeft + 2'h1;
        st_next.partsLeft = st_reg.partsLeft - 2'h1;
      end else begin
        pop = 1'b1;
        src = st_reg.buf0;
        st_next.word = st_reg.buf0;
        st_next.partsLeft = lastIdx;
      end
      st_next.dataOut = part_sel(src, idx, bus_match_select, byte_size_select,
                                 st_reg.endianBig);
      st_next.outValid = 1'b1;
      st_next.outLast = (idx == lastIdx);
      if (!fall_through_select && idx == lastIdx) begin
        st_next.freePtr = st_reg.freePtr + 1'b1;
      end
    end

    // two-entry buffer between memory and the output stage
    if (pop) begin
      st_next.buf0 = st_reg.buf1;
      cnt = st_reg.bufCnt - 2'h1;
    end
    push = (st_reg.rdPtr != st_reg.wptrS2) && (st_reg.bufCnt != 2'h2);
    if (push) begin
      if (cnt == 2'h0) begin
        st_next.buf0 = mem[st_reg.rdPtr[AW-1:0]];
      end else begin
        st_next.buf1 = mem[st_reg.rdPtr[AW-1:0]];
      end
      cnt = cnt + 2'h1;
      st_next.rdPtr = st_reg.rdPtr + 1'b1;
    end
    st_next.bufCnt = cnt;

    // retransmit rewinds to the first word after reset
    if (!retransmit_n) begin
      st_next.rdPtr = '0;
      st_next.freePtr = '0;
      st_next.bufCnt = 2'h0;
      st_next.partsLeft = 2'h0;
      st_next.outValid = 1'b0;
    end

    // mailboxes: the write wins over a same-cycle read unless the mailbox was already full
    if (mailRdB) begin
      st_next.mabFullN = 1'b1;
    end
    if (mailWrA && st_reg.mabFullN) begin
      st_next.mailAb = mail_mask(port_a_data_in, bus_match_select, byte_size_select);
      st_next.mabFullN = 1'b0;
    end
    if (mailRdA) begin
      st_next.mbaFullN = 1'b1;
    end
    if (mailWrB && st_reg.mbaFullN) begin
      st_next.mailBa = mail_mask(port_b_data_in, bus_match_select, byte_size_select);
      st_next.mbaFullN = 1'b0;
    end

    // resets; partial keeps the offsets
    if (inReset) begin
      st_next.wptr = '0;
      st_next.freePtr = '0;
      st_next.rdPtr = '0;
      st_next.wptrS1 = '0;
      st_next.wptrS2 = '0;
      st_next.freeS1 = '0;
      st_next.freeS2 = '0;
      // standard mode keeps its output stage one edge longer than fall-through
      if (st_reg.rstCnt != `BMSF_EF_RST_DLY_STD) begin
        st_next.bufCnt = 2'h0;
        st_next.partsLeft = 2'h0;
        st_next.outValid = 1'b0;
      end
      st_next.mabFullN = 1'b1;
      st_next.mbaFullN = 1'b1;
      if (st_reg.rstCnt != 2'h0) begin
        st_next.rstCnt = st_reg.rstCnt - 2'h1;
      end
    end else begin
      st_next.rstCnt = fall_through_select ? `BMSF_EF_RST_DLY_FALL_THROUGH_SELECT : `BMSF_EF_RST_DLY_STD;
    end
    if (!master_reset_n) begin
      st_next.phase = BMSF_CFG;
      st_next.afOffset = DEF_OFS;
      st_next.aeOffset = DEF_OFS;
      st_next.shiftCnt = '0;
      st_next.parCnt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (fifoWrA && fullN && !inReset) begin
      mem[st_reg.wptr[AW-1:0]] <= port_a_data_in;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    if (inReset && st_reg.rstCnt == 2'h0) begin
      empty_or_output_ready = 1'b0;
    end else if (fall_through_select) begin
      empty_or_output_ready = st_reg.outValid;
    end else begin
      empty_or_output_ready = avail;
    end
  end

  assign full_or_input_ready = fullN && !inReset;
  assign almost_empty_flag_n = !inReset && (wordsB > PW'(st_reg.aeOffset));
  assign almost_full_flag_n = !inReset &&
                              (wordsA < (DEPTH_P - PW'(st_reg.afOffset)));
  assign a_to_b_mail_full_n = st_reg.mabFullN;
  assign b_to_a_mail_full_n = st_reg.mbaFullN;
  assign port_a_data_oe = !port_a_chip_select_n && !port_a_direction;
  assign port_a_data_out = st_reg.mailBa;
  assign port_b_data_oe = !port_b_chip_select_n && port_b_direction;
  assign port_b_data_out = port_b_mail_select ? st_reg.mailAb : st_reg.dataOut;

endmodule

/* File: dv/bmsf_monitor.sv */
// port checker for the bus-matching fifo top
// assumes a bind onto bmsf_top and one clock for both ports
`timescale 1ns/100ps
module bmsf_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic master_reset_n,
  input wire logic partial_reset_n,
  input wire logic fall_through_select,
  input wire logic bus_match_select,
  input wire logic byte_size_select,
  input wire logic port_a_chip_select_n,
  input wire logic port_a_direction,
  input wire logic port_a_enable,
  input wire logic port_a_mail_select,
  input wire logic port_b_chip_select_n,
  input wire logic port_b_direction,
  input wire logic port_b_enable,
  input wire logic port_b_mail_select,
  input wire logic [35:0] port_b_data_out,
  input wire logic port_a_data_oe,
  input wire logic full_or_input_ready,
  input wire logic empty_or_output_ready,
  input wire logic a_to_b_mail_full_n
);
  // ----
  // access sequences
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n || !master_reset_n || !partial_reset_n);
  sequence aMailWr;
    !port_a_chip_select_n && port_a_enable && port_a_direction && port_a_mail_select;
  endsequence
  sequence bMailRd;
    !port_b_chip_select_n && port_b_enable && port_b_direction && port_b_mail_select;
  endsequence
  sequence aFifoWr;
    !port_a_chip_select_n && port_a_enable && port_a_direction && !port_a_mail_select &&
      full_or_input_ready && !empty_or_output_ready;
  endsequence
  // ----
  // checks
  // ----
  mail_set_a: assert property (a_to_b_mail_full_n ##0 aMailWr |=> !a_to_b_mail_full_n)
    else $error("mail flag did not drop after a write");
  mail_clear_a: assert property (!port_a_enable ##0 bMailRd |=> a_to_b_mail_full_n)
    else $error("mail flag did not rise after a read");
  half_lanes_a: assert property (bus_match_select && !byte_size_select |->
    port_b_data_out[35:18] == 18'h0) else $error("upper half lanes driven");
  byte_lanes_a: assert property (bus_match_select && byte_size_select |->
    port_b_data_out[35:9] == 27'h0) else $error("upper byte lanes driven");
  std_fill_a: assert property (aFifoWr ##0 !fall_through_select |->
    ##[1:4] empty_or_output_ready) else $error("empty flag late");
  ff_fill_a: assert property (aFifoWr ##0 fall_through_select |->
    ##[1:5] empty_or_output_ready) else $error("output ready late");
  rst_ff_a: assert property (disable iff (!rst_n)
    $fell(master_reset_n) && fall_through_select |=> !empty_or_output_ready)
    else $error("output ready not dropped");
  rst_std_a: assert property (disable iff (!rst_n)
    $fell(master_reset_n) && !fall_through_select |-> ##2 !empty_or_output_ready)
    else $error("empty flag not dropped");
  rst_hold_a: assert property (disable iff (!rst_n)
    $fell(partial_reset_n) && !fall_through_select && empty_or_output_ready |=>
    empty_or_output_ready ##1 !empty_or_output_ready) else $error("empty flag dropped early");
  a_drive_a: assert property (port_a_data_oe ==
    (!port_a_chip_select_n && !port_a_direction)) else $error("port a drive wrong");
endmodule

bind bmsf_top bmsf_monitor MON (
  .mclk(mclk), .rst_n(rst_n), .master_reset_n(master_reset_n),
  .partial_reset_n(partial_reset_n), .fall_through_select(fall_through_select),
  .bus_match_select(bus_match_select), .byte_size_select(byte_size_select),
  .port_a_chip_select_n(port_a_chip_select_n), .port_a_direction(port_a_direction),
  .port_a_enable(port_a_enable), .port_a_mail_select(port_a_mail_select),
  .port_b_chip_select_n(port_b_chip_select_n), .port_b_direction(port_b_direction),
  .port_b_enable(port_b_enable), .port_b_mail_select(port_b_mail_select),
  .port_b_data_out(port_b_data_out), .port_a_data_oe(port_a_data_oe),
  .full_or_input_ready(full_or_input_ready), .empty_or_output_ready(empty_or_output_ready),
  .a_to_b_mail_full_n(a_to_b_mail_full_n)
);

/* File: dv/bmsf_reader.sv */
// port b party: reads the fifo and mailbox, writes the b-to-a mailbox
// assumes the bench changes its requests just after a falling edge
`timescale 1ns/100ps
module bmsf_reader (
  input wire logic wantRead,
  input wire logic wantWrite,
  input wire logic useMail,
  input wire logic [35:0] mailData,
  output logic port_b_chip_select_n,
  output logic port_b_direction,
  output logic port_b_enable,
  output logic port_b_mail_select,
  output logic [35:0] port_b_data_in
);
  // reads only when asked, so a retransmit wait is honoured by the caller
  assign port_b_enable = wantRead || wantWrite;
  assign port_b_chip_select_n = !(wantRead || wantWrite);
  assign port_b_direction = !wantWrite;
  assign port_b_mail_select = useMail;
  // idle lines show the inverse so stale data never looks valid
  assign port_b_data_in = wantWrite ? mailData : ~mailData;
endmodule

/* File: dv/bmsf_top_bench.sv */
// self-checking bench of the bus-matching fifo
// assumes the design files and the port b model are compiled first
`timescale 1ns/100ps
module bmsf_top_bench;
  import bmsf_pkg::*;
  localparam int DEPTH = 16;
  localparam int AW = $clog2(DEPTH);
  logic mclk = 0, rst_n = 0, master_reset_n = 1, partial_reset_n = 1, retransmit_n = 1;
  logic endian_select = 0, fall_through_select = 0, bus_match_select = 0, byte_size_select = 0;
  bmsf_prog_e program_mode = BMSF_PROG_DEFAULT;
  logic serial_load_enable = 0, serial_offset_data = 0, port_a_enable = 0;
  logic port_a_chip_select_n = 1, port_a_direction = 1, port_a_mail_select = 0;
  logic wantRead = 0, wantWrite = 0, useMail = 0;
  logic [35:0] port_a_data_in = 36'h0, mailData = 36'h0;
  wire logic [35:0] port_a_data_out, port_b_data_out, port_b_data_in;
  wire logic port_b_chip_select_n, port_b_direction, port_b_enable, port_b_mail_select;
  wire logic port_a_data_oe, port_b_data_oe, full_or_input_ready, empty_or_output_ready;
  wire logic almost_empty_flag_n, almost_full_flag_n, a_to_b_mail_full_n, b_to_a_mail_full_n;
  int miscompares = 0, samplesChecked = 0;
  bmsf_top #(.DEPTH(DEPTH), .DEFAULT_OFFSET(2)) DUT (
    .mclk(mclk), .rst_n(rst_n), .master_reset_n(master_reset_n),
    .partial_reset_n(partial_reset_n), .retransmit_n(retransmit_n),
    .endian_select(endian_select), .fall_through_select(fall_through_select),
    .bus_match_select(bus_match_select), .byte_size_select(byte_size_select),
    .program_mode(program_mode), .serial_load_enable(serial_load_enable),
    .serial_offset_data(serial_offset_data), .port_a_chip_select_n(port_a_chip_select_n),
    .port_a_direction(port_a_direction), .port_a_enable(port_a_enable),
    .port_a_mail_select(port_a_mail_select), .port_a_data_in(port_a_data_in),
    .port_a_data_out(port_a_data_out), .port_a_data_oe(port_a_data_oe),
    .port_b_chip_select_n(port_b_chip_select_n), .port_b_direction(port_b_direction),
    .port_b_enable(port_b_enable), .port_b_mail_select(port_b_mail_select),
    .port_b_data_in(port_b_data_in), .port_b_data_out(port_b_data_out),
    .port_b_data_oe(port_b_data_oe), .full_or_input_ready(full_or_input_ready),
    .empty_or_output_ready(empty_or_output_ready), .almost_empty_flag_n(almost_empty_flag_n),
    .almost_full_flag_n(almost_full_flag_n), .a_to_b_mail_full_n(a_to_b_mail_full_n),
    .b_to_a_mail_full_n(b_to_a_mail_full_n)
  );
  bmsf_reader PEER (
    .wantRead(wantRead), .wantWrite(wantWrite), .useMail(useMail), .mailData(mailData),
    .port_b_chip_select_n(port_b_chip_select_n), .port_b_direction(port_b_direction),
    .port_b_enable(port_b_enable), .port_b_mail_select(port_b_mail_select),
    .port_b_data_in(port_b_data_in)
  );
  initial forever #5 mclk = ~mclk;
  // ----
  // shared tasks
  // ----
  task automatic finalReport();
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check36(input logic [35:0] got, input logic [35:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic checkBit(input logic got, input logic exp);
    check36(36'(got), 36'(exp));
  endtask
  task automatic waitFor(input bit fullSide);
    int n;
    n = 0;
    while ((fullSide ? full_or_input_ready : empty_or_output_ready) !== 1'b1) begin
      @(negedge mclk);
      n++;
      if (n > 200) begin
        miscompares++;
        finalReport();
      end
    end
  endtask
  task automatic resetAll(input logic ff, bm, sz, big, input bmsf_prog_e pm);
    @(negedge mclk);
    rst_n = 0;
    {fall_through_select, bus_match_select, byte_size_select, endian_select} = {ff, bm, sz, big};
    program_mode = pm;
    repeat (2) @(negedge mclk);
    rst_n = 1;
    @(negedge mclk);
    master_reset_n = 0;
    repeat (3) @(negedge mclk);
    master_reset_n = 1;
    @(negedge mclk);
    endian_select = ~big;
  endtask
  task automatic aCycle(input logic [35:0] w, input logic mail, dir, wt);
    @(negedge mclk);
    {port_a_data_in, port_a_mail_select, port_a_direction} = {w, mail, dir};
    port_a_chip_select_n = 0;
    port_a_enable = 1;
    if (wt) waitFor(1);
    @(negedge mclk);
    port_a_enable = 0;
    port_a_chip_select_n = 1;
  endtask
  task automatic bPart(input logic [35:0] exp);
    @(negedge mclk);
    waitFor(0);
    if (fall_through_select) check36(port_b_data_out, exp);
    wantRead = 1;
    @(negedge mclk);
    wantRead = 0;
    if (!fall_through_select) check36(port_b_data_out, exp);
  endtask
  task automatic bCycle(input logic rd, wr, input logic [35:0] exp);
    @(negedge mclk);
    {useMail, wantRead, wantWrite} = {1'b1, rd, wr};
    @(negedge mclk);
    if (rd) check36(port_b_data_out, exp);
    checkBit(port_b_data_oe, rd);
    {useMail, wantRead, wantWrite} = 3'h0;
  endtask
  // ----
  // scenarios
  // ----
  task automatic busModes();
    logic [35:0] w;
    int parts, wd, idx;
    for (int m = 0; m < 12; m++) begin
      resetAll(m[0], m[3:2] != 0, m[3], m[1], BMSF_PROG_DEFAULT);
      parts = 1 << m[3:2];
      wd = 36 / parts;
      for (int k = 0; k < 2; k++) aCycle(36'h9_A5C3_1E7F ^ 36'(k), 0, 1, 1);
      for (int k = 0; k < 2; k++) begin
        w = 36'h9_A5C3_1E7F ^ 36'(k);
        for (int p = 0; p < parts; p++) begin
          idx = m[1] ? parts - 1 - p : p;
          bPart((w >> (idx * wd)) & ((36'h1 << wd) - 36'h1));
        end
      end
      repeat (3) @(negedge mclk);
      checkBit(empty_or_output_ready, 0);
    end
  endtask
  task automatic offsets(input bit serial);
    logic [2*AW-1:0] bits;
    bits = {AW'(1), AW'(3)};
    resetAll(serial, 0, 0, 0, serial ? BMSF_PROG_SERIAL : BMSF_PROG_PARALLEL);
    repeat (3) @(negedge mclk);
    checkBit(full_or_input_ready, 0);
    if (serial) begin
      aCycle(36'h7, 0, 1, 0);
      for (int i = 2 * AW - 1; i >= 0; i--) begin
        serial_offset_data = bits[i];
        serial_load_enable = 1;
        @(negedge mclk);
        serial_load_enable = 0;
        serial_offset_data = ~bits[i];
        @(negedge mclk);
      end
    end else begin
      aCycle(36'(bits[2*AW-1:AW]), 0, 1, 0);
      aCycle(36'(bits[AW-1:0]), 0, 1, 0);
    end
    waitFor(1);
    repeat (5) @(negedge mclk);
    checkBit(empty_or_output_ready, 0);
    repeat (3) aCycle(36'h5, 0, 1, 1);
    repeat (6) @(negedge mclk);
    checkBit(almost_empty_flag_n, 0);
    aCycle(36'h6, 0, 1, 1);
    repeat (6) @(negedge mclk);
    checkBit(almost_empty_flag_n, 1);
    checkBit(almost_full_flag_n, 1);
    repeat (11) aCycle(36'h6, 0, 1, 1);
    checkBit(almost_full_flag_n, 0);
    aCycle(36'h6, 0, 1, 1);
    checkBit(full_or_input_ready, 0);
    bPart(36'h5);
    repeat (2) @(negedge mclk);
    checkBit(full_or_input_ready, 1);
  endtask
  task automatic mailRetx();
    resetAll(0, 1, 0, 0, BMSF_PROG_DEFAULT);
    aCycle(36'hF_FFFF_FFFF, 1, 1, 0);
    checkBit(a_to_b_mail_full_n, 0);
    aCycle(36'h0, 1, 1, 0);
    bCycle(1, 0, 36'h3_FFFF);
    checkBit(a_to_b_mail_full_n, 1);
    mailData = 36'hA_BCDE_1234;
    bCycle(0, 1, 36'h0);
    checkBit(b_to_a_mail_full_n, 0);
    aCycle(36'h0, 1, 0, 0);
    check36(port_a_data_out, 36'h2_1234);
    checkBit(b_to_a_mail_full_n, 1);
    for (int k = 0; k < 3; k++) aCycle(36'h4_0003_8001 + 36'(k), 0, 1, 1);
    bPart(36'h3_8001);
    bPart(36'h1_0000);
    @(negedge mclk);
    retransmit_n = 0;
    @(negedge mclk);
    retransmit_n = 1;
    repeat (2) @(negedge mclk);
    bPart(36'h3_8001);
    partial_reset_n = 0;
    repeat (2) @(negedge mclk);
    partial_reset_n = 1;
    waitFor(1);
    repeat (2) @(negedge mclk);
    checkBit(empty_or_output_ready, 0);
  endtask
  initial begin
    busModes();
    offsets(0);
    offsets(1);
    mailRetx();
    finalReport();
  end
endmodule
